// *** src/bisl_ctrl_if.sv ***
// Carrier between the top level and the vector unit.
// Assumes both ends run on the processor clock.
`timescale 1ns/1ns
`default_nettype none

interface bisl_ctrl_if;
	logic [7:0] req;
	logic inta;
	logic slave_mode;
	logic [2:0] cas_in;
	logic [4:0] base;
	logic [7:0] casc_word;
	logic [7:0] vector;
	logic vector_valid;
	logic [2:0] cas_out;
	logic cas_drive;
	logic int_req;

	modport ctrl (
		output req, inta, slave_mode, cas_in, base, casc_word,
		input vector, vector_valid, cas_out, cas_drive, int_req
	);

	modport unit (
		input req, inta, slave_mode, cas_in, base, casc_word,
		output vector, vector_valid, cas_out, cas_drive, int_req
	);
endinterface

`default_nettype wire

// *** src/bisl_params.svh ***
// Constants for the board interrupt and status logic: port addresses,
// status latch bit positions, reset values and controller init details.
// Assumes a 16-bit I/O address whose upper byte is zero for board ports.
`ifndef BISL_PARAMS_SVH
`define BISL_PARAMS_SVH

// ****************************************************************
// I/O port map
// ****************************************************************
`define BISL_STATUS_LO 16'h00c9
`define BISL_STATUS_HI 16'h00df
`define BISL_EDGE_CLR_LO 16'h00c1
`define BISL_EDGE_CLR_HI 16'h00c7
`define BISL_PAGE_PORT 16'h00d7
`define BISL_CMD_PORT 16'h00c0
`define BISL_DATA_PORT 16'h00c2

// ****************************************************************
// Status latch fields
// ****************************************************************
`define BISL_BIT_GATE0 0
`define BISL_BIT_GATE1 1
`define BISL_BIT_NMI_EN 2
`define BISL_BIT_HOLD 3
`define BISL_BIT_BUSIRQ0 4
`define BISL_BIT_BUSIRQ1 5
`define BISL_BIT_USER_LAMP 6
`define BISL_BIT_PAGE_INH 7
`define BISL_STATUS_RESET 8'h00
`define BISL_PAGE_RESET 4'h0

// ****************************************************************
// Controller init and request routing
// ****************************************************************
`define BISL_INIT_BIT 4
`define BISL_BASE_RESET 5'h00
`define BISL_CASC_RESET 8'h00
`define BISL_EDGE_IR 7

`endif

// *** src/bisl_pkg.sv ***
// Types for the board interrupt and status logic.
// Assumes bisl_params.svh is not needed here; only state layouts live here.
package bisl_pkg;

	typedef enum logic [1:0] {bisl_init_idle, bisl_init_base, bisl_init_casc} bisl_init_e;

	typedef enum logic {bisl_ack_first, bisl_ack_second} bisl_ack_e;

	typedef struct packed {
		logic [7:0] status;
		logic [3:0] page;
		logic edge_latched;
		logic [1:0] nmi_sync;
		logic [2:0] edge_sync;
		logic [7:0] req_s1;
		logic [7:0] req_s2;
		logic [2:0] cas_s1;
		logic [2:0] cas_s2;
		bisl_init_e init;
		logic [4:0] base;
		logic [7:0] casc_word;
	} bisl_top_s;

	typedef struct packed {
		bisl_ack_e phase;
		logic [2:0] win_idx;
		logic win_slave;
		logic [7:0] vector;
		logic vector_valid;
		logic [2:0] cas_out;
		logic cas_drive;
	} bisl_vec_s;

endpackage

// *** src/bisl_vector_unit.sv ***
// Vector unit: resolves the winning request on the first acknowledge and
// returns the type byte or the cascade code. Assumes synchronised inputs.
`timescale 1ns/1ns
`default_nettype none

module bisl_vector_unit (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	bisl_ctrl_if.unit bus
);

	bisl_pkg::bisl_vec_s s_r;
	bisl_pkg::bisl_vec_s s_nxt;
	logic [2:0] first_idx;

	// Input zero has the highest priority
	function automatic logic [2:0] bisl_pick(input logic [7:0] req);
		logic [2:0] idx;
		idx = 3'h7;
		for (int i = 7; i >= 0; i--) begin
			if (req[i]) begin
				idx = i[2:0];
			end
		end
		return idx;
	endfunction

	assign first_idx = bisl_pick(bus.req);

	always_comb begin
		s_nxt = s_r;
		s_nxt.vector_valid = 1'b0;
		case (s_r.phase)
			bisl_pkg::bisl_ack_first: begin
				if (bus.inta) begin
					s_nxt.phase = bisl_pkg::bisl_ack_second; // R05
					s_nxt.win_idx = first_idx;
					s_nxt.win_slave = !bus.slave_mode && bus.casc_word[first_idx];
					if (!bus.slave_mode && bus.casc_word[first_idx]) begin
						s_nxt.cas_out = first_idx; // R10
						s_nxt.cas_drive = 1'b1;
					end
				end
			end
			bisl_pkg::bisl_ack_second: begin
				if (bus.inta) begin
					s_nxt.phase = bisl_pkg::bisl_ack_first;
					s_nxt.cas_drive = 1'b0;
					if (bus.slave_mode) begin
						if (bus.cas_in == bus.casc_word[2:0]) begin // R09 R10
							s_nxt.vector = {bus.base, s_r.win_idx}; // R08
							s_nxt.vector_valid = 1'b1;
						end
					end else if (!s_r.win_slave) begin // R07
						s_nxt.vector = {bus.base, s_r.win_idx}; // R08
						s_nxt.vector_valid = 1'b1; // R05
					end
				end
			end
			default: begin
				s_nxt.phase = bisl_pkg::bisl_ack_first;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			s_r <= '{phase: bisl_pkg::bisl_ack_first, win_idx: 3'h0, win_slave: 1'b0,
				vector: 8'h00, vector_valid: 1'b0, cas_out: 3'h0, cas_drive: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bus.vector = s_r.vector;
	assign bus.vector_valid = s_r.vector_valid;
	assign bus.cas_out = s_r.cas_out;
	assign bus.cas_drive = s_r.cas_drive;
	assign bus.int_req = |bus.req;

	chk_vec_direct_byte: assert property ( // R08
		@(posedge clk_sys_in) disable iff (rst_in)
		(s_r.phase == bisl_pkg::bisl_ack_second && bus.inta && !bus.slave_mode && !s_r.win_slave)
		|=> (bus.vector_valid && bus.vector == {$past(bus.base), $past(s_r.win_idx)}))
		else $error("direct source type byte wrong");

	chk_vec_cascade_quiet: assert property ( // R07
		@(posedge clk_sys_in) disable iff (rst_in)
		(s_r.phase == bisl_pkg::bisl_ack_second && bus.inta && !bus.slave_mode && s_r.win_slave)
		|=> !bus.vector_valid)
		else $error("master drove byte for cascaded slave");

	chk_cas_code_out: assert property ( // R10
		@(posedge clk_sys_in) disable iff (rst_in)
		(s_r.phase == bisl_pkg::bisl_ack_first && bus.inta && !bus.slave_mode
			&& bus.casc_word[first_idx])
		|=> (bus.cas_drive && bus.cas_out == $past(first_idx)) [*1]
		##1 (bus.cas_drive || $past(bus.inta)))
		else $error("cascade code not driven on first acknowledge");

	chk_slave_id_match: assert property ( // R09
		@(posedge clk_sys_in) disable iff (rst_in)
		(s_r.phase == bisl_pkg::bisl_ack_second && bus.inta && bus.slave_mode
			&& bus.cas_in != bus.casc_word[2:0])
		|=> !bus.vector_valid)
		else $error("unaddressed slave answered");

endmodule

`default_nettype wire

// *** src/board_interrupt_status_logic.sv ***
// Top level of the board interrupt and status logic: status latch, edge
// latch, request gating and the controller init sequence.
// Assumes processor I/O strobes are on clk_sys_in; pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none

`include "bisl_params.svh"

// Operation
// R01: Processor serves the non-maskable request ahead of the maskable one.
// R02: Non-maskable rising edge is taken at instruction or block-move end.
// R03: Non-maskable service pushes flags, clears enable, calls through 00008.
// R04: Maskable high level is taken at instruction end while enabled.
// R05: Two acknowledges; the type byte returns on the second one.
// R06: Processor multiplies the type by 4 and calls through that vector.
// R07: Master returns the byte only for directly attached winning sources.
// R08: Type byte is five base bits joined with the 3-bit input number.
// R09: Slave holds a 3-bit identity and requests through one master input.
// R10: Master puts slave code on cascade lines; only matching slave answers.
// R11: Write-only 8-bit latch loads on odd port writes C9H through DFH.
// R12: Latch bits 0 and 1 enable the two timer gates.
// R13: Latch bit 2 one passes the non-maskable request, zero blocks it.
// R14: Latch bit 3 one asserts the active-low dual port hold.
// R15: Latch bits 4 and 5 raise bus interrupts and darken the bus lamp.
// R16: Latch bit 6 one turns the user lamp off, zero on.
// R17: Latch bit 7 one stops the page register at D7 from loading.
// R18: Edge flip-flop captures an edge and holds it as a level request.
// R19: Any write to odd ports C1H through C7H clears the edge latch; here a rising edge in the same cycle keeps it set.
// R20: Reset clears the latch and edge flop; outputs go to safe state.
module board_interrupt_status_logic (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic io_wr_in,
	input wire logic [15:0] io_addr_in,
	input wire logic [7:0] io_data_in,
	input wire logic inta_in,
	input wire logic slave_mode_in,
	input wire logic nmi_pin_in,
	input wire logic edge_irq_pin_in,
	input wire logic [7:0] request_inputs_in,
	input wire logic [2:0] cascade_in,
	output logic nmi_out,
	output logic maskable_request_out,
	output logic [7:0] vector_data_out,
	output logic vector_valid_out,
	output logic [2:0] cascade_out,
	output logic cascade_oe_n_out,
	output logic [1:0] timer_gate_out,
	output logic dual_port_hold_n_out,
	output logic [1:0] bus_irq_n_out,
	output logic bus_request_lamp_on_out,
	output logic user_lamp_on_out,
	output logic page_load_inhibit_out,
	output logic [3:0] page_addr_out,
	output logic edge_request_out
);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************

	// Only odd addresses inside the window hit; even ones belong to others
	function automatic logic bisl_odd_hit(input logic [15:0] addr,
		input logic [15:0] lo, input logic [15:0] hi);
		return addr[0] && (addr >= lo) && (addr <= hi);
	endfunction

	bisl_pkg::bisl_top_s s_r;
	bisl_pkg::bisl_top_s s_nxt;
	bisl_ctrl_if ctl ();

	logic status_wr;
	logic edge_clr;
	logic page_wr;
	logic cmd_wr;
	logic data_wr;
	logic edge_rise;
	logic [7:0] req_routed;

	assign status_wr = io_wr_in && bisl_odd_hit(io_addr_in, `BISL_STATUS_LO, `BISL_STATUS_HI);
	assign edge_clr = io_wr_in && bisl_odd_hit(io_addr_in, `BISL_EDGE_CLR_LO, `BISL_EDGE_CLR_HI);
	assign page_wr = io_wr_in && (io_addr_in == `BISL_PAGE_PORT);
	assign cmd_wr = io_wr_in && (io_addr_in == `BISL_CMD_PORT);
	assign data_wr = io_wr_in && (io_addr_in == `BISL_DATA_PORT);

	// Compares the second stage against its own previous value
	assign edge_rise = s_r.edge_sync[1] && !s_r.edge_sync[2];

	// ****************************************************************
	// Next state
	// ****************************************************************

	always_comb begin
		s_nxt = s_r;

		// Two-flop synchronisers for every pin input
		s_nxt.nmi_sync = {s_r.nmi_sync[0], nmi_pin_in};
		s_nxt.edge_sync = {s_r.edge_sync[1], s_r.edge_sync[0], edge_irq_pin_in};
		s_nxt.req_s1 = request_inputs_in;
		s_nxt.req_s2 = s_r.req_s1;
		s_nxt.cas_s1 = cascade_in;
		s_nxt.cas_s2 = s_r.cas_s1;

		if (status_wr) begin
			s_nxt.status = io_data_in; // R11
		end

		// The inhibit is the latch value before this write lands
		if (page_wr && !s_r.status[`BISL_BIT_PAGE_INH]) begin
			s_nxt.page = io_data_in[3:0]; // R17
		end

		// Set wins over clear so an edge in the clearing cycle survives
		if (edge_rise) begin
			s_nxt.edge_latched = 1'b1; // R18
		end else if (edge_clr) begin
			s_nxt.edge_latched = 1'b0; // R19
		end

		case (s_r.init)
			bisl_pkg::bisl_init_idle: begin
				if (cmd_wr && io_data_in[`BISL_INIT_BIT]) begin
					s_nxt.init = bisl_pkg::bisl_init_base;
				end
			end
			bisl_pkg::bisl_init_base: begin
				if (data_wr) begin
					s_nxt.base = io_data_in[7:3]; // R08
					s_nxt.init = bisl_pkg::bisl_init_casc;
				end
			end
			bisl_pkg::bisl_init_casc: begin
				if (data_wr) begin
					s_nxt.casc_word = io_data_in; // R09
					s_nxt.init = bisl_pkg::bisl_init_idle;
				end
			end
			default: begin
				s_nxt.init = bisl_pkg::bisl_init_idle;
			end
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			s_r <= '{status: `BISL_STATUS_RESET, page: `BISL_PAGE_RESET, // R20
				edge_latched: 1'b0, nmi_sync: 2'h0, edge_sync: 3'h0,
				req_s1: 8'h00, req_s2: 8'h00, cas_s1: 3'h0, cas_s2: 3'h0,
				init: bisl_pkg::bisl_init_idle, base: `BISL_BASE_RESET,
				casc_word: `BISL_CASC_RESET};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// Vector unit
	// ****************************************************************

	// Edge latch feeds one controller input as a level request
	always_comb begin
		req_routed = s_r.req_s2;
		req_routed[`BISL_EDGE_IR] = s_r.req_s2[`BISL_EDGE_IR] || s_r.edge_latched; // R18
	end

	assign ctl.req = req_routed;
	assign ctl.inta = inta_in;
	assign ctl.slave_mode = slave_mode_in;
	assign ctl.cas_in = s_r.cas_s2;
	assign ctl.base = s_r.base;
	assign ctl.casc_word = s_r.casc_word;

	bisl_vector_unit u_vector (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.bus(ctl)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************

	assign maskable_request_out = ctl.int_req; // R05
	assign vector_data_out = ctl.vector;
	assign vector_valid_out = ctl.vector_valid;
	assign cascade_out = ctl.cas_out;
	assign cascade_oe_n_out = !ctl.cas_drive; // R10

	// Gate is a level; the processor does its own edge detection
	assign nmi_out = s_r.nmi_sync[1] && s_r.status[`BISL_BIT_NMI_EN]; // R13
	assign timer_gate_out = {s_r.status[`BISL_BIT_GATE1], s_r.status[`BISL_BIT_GATE0]}; // R12
	assign dual_port_hold_n_out = !s_r.status[`BISL_BIT_HOLD]; // R14
	assign bus_irq_n_out = {!s_r.status[`BISL_BIT_BUSIRQ1], !s_r.status[`BISL_BIT_BUSIRQ0]}; // R15
	assign bus_request_lamp_on_out =
		!(s_r.status[`BISL_BIT_BUSIRQ0] || s_r.status[`BISL_BIT_BUSIRQ1]); // R15
	assign user_lamp_on_out = !s_r.status[`BISL_BIT_USER_LAMP]; // R16
	assign page_load_inhibit_out = s_r.status[`BISL_BIT_PAGE_INH]; // R17
	assign page_addr_out = s_r.page;
	assign edge_request_out = s_r.edge_latched;

	// ****************************************************************
	// Checks
	// ****************************************************************

	chk_status_load_byte: assert property ( // R11
		@(posedge clk_sys_in) disable iff (rst_in)
		status_wr |=> (s_r.status == $past(io_data_in)))
		else $error("status latch did not load");

	chk_status_even_ignored: assert property ( // R11
		@(posedge clk_sys_in) disable iff (rst_in)
		(io_wr_in && !io_addr_in[0]) |=> $stable(s_r.status))
		else $error("even port write changed status latch");

	chk_nmi_mask_block: assert property ( // R13
		@(posedge clk_sys_in) disable iff (rst_in)
		!s_r.status[`BISL_BIT_NMI_EN] |-> !nmi_out)
		else $error("masked request reached processor");

	chk_edge_hold_level: assert property ( // R18
		@(posedge clk_sys_in) disable iff (rst_in)
		(edge_request_out && !edge_clr) |=> edge_request_out)
		else $error("edge latch dropped without clear");

	chk_edge_capture: assert property ( // R18
		@(posedge clk_sys_in) disable iff (rst_in)
		$rose(s_r.edge_sync[1]) |=> edge_request_out ##1 (edge_request_out || $past(edge_clr)))
		else $error("edge not captured");

	chk_edge_clear_write: assert property ( // R19
		@(posedge clk_sys_in) disable iff (rst_in)
		(edge_clr && !edge_rise) |=> !edge_request_out)
		else $error("edge latch not cleared by write");

	chk_page_inhibit_hold: assert property ( // R17
		@(posedge clk_sys_in) disable iff (rst_in)
		(page_wr && page_load_inhibit_out) |=> $stable(page_addr_out))
		else $error("page loaded while inhibited");

	chk_reset_safe_state: assert property ( // R20
		@(posedge clk_sys_in) disable iff (rst_in)
		$fell(rst_in) |-> (!nmi_out && timer_gate_out == 2'h0
			&& bus_irq_n_out == 2'h3 && !edge_request_out))
		else $error("outputs not safe after reset");

	chk_status_other_kept: assert property ( // R11
		@(posedge clk_sys_in) disable iff (rst_in)
		(io_wr_in && !status_wr) |=> $stable(s_r.status))
		else $error("status latch changed by another port");

	chk_timer_gate_map: assert property ( // R12
		@(posedge clk_sys_in) disable iff (rst_in)
		status_wr |=> (timer_gate_out == $past(io_data_in[1:0])))
		else $error("timer gates do not follow latch");

	chk_nmi_mask_pass: assert property ( // R13
		@(posedge clk_sys_in) disable iff (rst_in)
		(s_r.status[`BISL_BIT_NMI_EN] && s_r.nmi_sync[1]) |-> nmi_out)
		else $error("enabled request did not reach processor");

	chk_hold_active_low: assert property ( // R14
		@(posedge clk_sys_in) disable iff (rst_in)
		status_wr |=> (dual_port_hold_n_out == !$past(io_data_in[3])))
		else $error("dual port hold level wrong");

	chk_bus_irq_drive: assert property ( // R15
		@(posedge clk_sys_in) disable iff (rst_in)
		status_wr |=> (bus_irq_n_out == ~$past(io_data_in[5:4])))
		else $error("bus interrupt requests wrong");

	chk_bus_lamp_dark: assert property ( // R15
		@(posedge clk_sys_in) disable iff (rst_in)
		status_wr |=> (bus_request_lamp_on_out == !($past(io_data_in[4]) || $past(io_data_in[5]))))
		else $error("bus request lamp wrong");

	chk_user_lamp_level: assert property ( // R16
		@(posedge clk_sys_in) disable iff (rst_in)
		status_wr |=> (user_lamp_on_out == !$past(io_data_in[6])))
		else $error("user lamp wrong");

	chk_page_load_open: assert property ( // R17
		@(posedge clk_sys_in) disable iff (rst_in)
		(page_wr && !page_load_inhibit_out) |=> (page_addr_out == $past(io_data_in[3:0])))
		else $error("page not loaded while open");

	chk_edge_set_wins: assert property ( // R18
		@(posedge clk_sys_in) disable iff (rst_in)
		(edge_rise && edge_clr) |=> edge_request_out)
		else $error("edge lost to clear in same cycle");

	chk_request_level_out: assert property ( // R05
		@(posedge clk_sys_in) disable iff (rst_in)
		(s_r.req_s2 != 8'h00) |-> maskable_request_out)
		else $error("pending request not raised");

	chk_reset_clears_latch: assert property ( // R20
		@(posedge clk_sys_in) disable iff (rst_in)
		$fell(rst_in) |-> (s_r.status == `BISL_STATUS_RESET && page_addr_out == `BISL_PAGE_RESET
			&& !vector_valid_out && cascade_oe_n_out))
		else $error("latches not cleared by reset");

endmodule

`default_nettype wire

// *** tb/bisl_cpu_model.sv ***
// Behavioural processor core facing the board interrupt and status logic.
// Assumes the bench calls its tasks; all strobes change at falling edges.
`timescale 1ns/1ns
`default_nettype none

module bisl_cpu_model (
	input wire logic clk_sys_in,
	input wire logic nmi_in,
	input wire logic mreq_in,
	input wire logic [7:0] vec_in,
	input wire logic vec_valid_in,
	output logic io_wr_out,
	output logic [15:0] io_addr_out,
	output logic [7:0] io_data_out,
	output logic inta_out
);
	logic ie_flag = 1'b1;
	logic nmi_prev = 1'b0;
	int nmi_rises = 0;
	int nmi_served = 0;

	initial begin
		io_wr_out = 1'b0;
		io_addr_out = 16'h0000;
		io_data_out = 8'h00;
		inta_out = 1'b0;
	end

	// Only a rising edge counts; a level held high is served once
	always @(posedge clk_sys_in) begin
		nmi_prev <= nmi_in;
		if (nmi_in && !nmi_prev) begin
			nmi_rises <= nmi_rises + 1;
		end
	end

	task automatic arm_core();
		ie_flag = 1'b1;
		nmi_served = nmi_rises;
	endtask

	// Idle bus shows the inverse so a stale value cannot pass for a good one
	task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
		@(negedge clk_sys_in);
		io_wr_out = 1'b1;
		io_addr_out = addr;
		io_data_out = data;
		@(negedge clk_sys_in);
		io_wr_out = 1'b0;
		io_addr_out = ~addr;
		io_data_out = ~data;
	endtask

	task automatic pulse_ack();
		inta_out = 1'b1;
		@(negedge clk_sys_in);
		inta_out = 1'b0;
	endtask

	task automatic serve(output logic [19:0] target, output logic answered);
		int n;
		target = 20'hf_ffff;
		answered = 1'b0;
		@(negedge clk_sys_in);
		if (nmi_rises != nmi_served) begin
			nmi_served = nmi_rises;
			ie_flag = 1'b0;
			target = 20'h0_0008;
			answered = 1'b1;
		end else if (ie_flag && mreq_in) begin
			pulse_ack();
			repeat (3) @(negedge clk_sys_in);
			pulse_ack();
			for (n = 0; n < 4 && !answered; n++) begin
				if (vec_valid_in === 1'b1) begin
					target = {10'h000, vec_in, 2'b00};
					answered = 1'b1;
					ie_flag = 1'b0;
				end else begin
					@(negedge clk_sys_in);
				end
			end
		end
	endtask
endmodule

`default_nettype wire

// *** tb/board_interrupt_status_logic_tb.sv ***
// Self-checking bench for the board interrupt and status logic.
// Assumes the core model owns the I/O strobe and acknowledge lines.
`timescale 1ns/1ns
`default_nettype none

module board_interrupt_status_logic_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic io_wr, inta, slave_mode, nmi_pin, edge_pin, nmi, mreq, vvalid, cas_oe_n;
	logic hold_n, bus_lamp, user_lamp, inhibit, edge_req, ans;
	logic cas_low = 1'b0;
	logic [15:0] io_addr;
	logic [7:0] io_data, reqs, vec;
	logic [2:0] cas_in, cas_out, cas_seen;
	logic [1:0] gates, bus_irq_n;
	logic [3:0] page;
	logic [19:0] target;
	logic [15:0] bad_ports [4] = '{16'h00c8, 16'h00de, 16'h00e1, 16'h01c9};
	logic [15:0] clr_ports [4] = '{16'h00c1, 16'h00c3, 16'h00c5, 16'h00c7};
	logic [7:0] pg_data [4] = '{8'h05, 8'h8a, 8'h03, 8'h06};
	logic [3:0] pg_exp [4] = '{4'h5, 4'ha, 4'ha, 4'h6};
	int bad_count = 0;
	int checked = 0;

	always #50 clk_sys = ~clk_sys;

	board_interrupt_status_logic dut_u (.clk_sys_in(clk_sys), .rst_in(rst), .io_wr_in(io_wr),
		.io_addr_in(io_addr), .io_data_in(io_data), .inta_in(inta),
		.slave_mode_in(slave_mode), .nmi_pin_in(nmi_pin), .edge_irq_pin_in(edge_pin),
		.request_inputs_in(reqs), .cascade_in(cas_in), .nmi_out(nmi),
		.maskable_request_out(mreq), .vector_data_out(vec), .vector_valid_out(vvalid),
		.cascade_out(cas_out), .cascade_oe_n_out(cas_oe_n), .timer_gate_out(gates),
		.dual_port_hold_n_out(hold_n), .bus_irq_n_out(bus_irq_n),
		.bus_request_lamp_on_out(bus_lamp), .user_lamp_on_out(user_lamp),
		.page_load_inhibit_out(inhibit), .page_addr_out(page), .edge_request_out(edge_req));

	bisl_cpu_model cpu_u (.clk_sys_in(clk_sys), .nmi_in(nmi), .mreq_in(mreq), .vec_in(vec),
		.vec_valid_in(vvalid), .io_wr_out(io_wr), .io_addr_out(io_addr),
		.io_data_out(io_data), .inta_out(inta));

	// Cascade drive lasts only between the acknowledges, so catch it here
	always @(negedge clk_sys) begin
		if (cas_oe_n === 1'b0) begin
			cas_low = 1'b1;
			cas_seen = cas_out;
		end
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("counts: checked=%0d bad=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic check_reset();
		check({gates, nmi, hold_n, bus_irq_n, bus_lamp, user_lamp, inhibit, edge_req, cas_oe_n,
			vvalid, page}, {2'b00, 1'b0, 1'b1, 2'b11, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0});
	endtask

	// Expects the non-maskable pin held high
	task automatic check_status(input logic [7:0] d);
		check({gates, nmi, hold_n, bus_irq_n, bus_lamp, user_lamp, inhibit},
			{d[1:0], d[2], ~d[3], ~d[5:4], ~(d[4] | d[5]), ~d[6], d[7]});
	endtask

	task automatic init_ctl(input logic [7:0] base, input logic [7:0] casc);
		cpu_u.io_write(16'h00c0, 8'h10);
		cpu_u.io_write(16'h00c2, base);
		cpu_u.io_write(16'h00c2, casc);
	endtask

	initial begin
		#2000000;
		bad_count++;
		stop_test();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		int i;
		logic [7:0] d;
		slave_mode = 1'b0;
		nmi_pin = 1'b1;
		edge_pin = 1'b0;
		reqs = 8'h00;
		cas_in = 3'b000;
		wait_n(12);
		rst = 1'b0;
		check_reset();
		$display("test reset done");

		for (i = 0; i < 12; i++) begin
			d = 8'h01 << (i % 8);
			if (i % 2 == 1) d = ~d;
			cpu_u.io_write(16'h00c9 + 16'(2 * i), d);
			check_status(d);
		end
		for (i = 0; i < 4; i++) begin
			cpu_u.io_write(bad_ports[i], 8'h00);
			check_status(8'hf7);
		end
		cpu_u.io_write(16'h00c9, 8'h00);
		for (i = 0; i < 4; i++) begin
			cpu_u.io_write(16'h00d7, pg_data[i]);
			check({inhibit, page}, {pg_data[i][7], pg_exp[i]});
		end
		$display("test status latch done");

		for (i = 0; i < 4; i++) begin
			edge_pin = 1'b0;
			wait_n(3);
			edge_pin = 1'b1;
			wait_n(4);
			check({edge_req, mreq}, 2'b11);
			cpu_u.io_write(16'h00c4, 8'h00);
			check(edge_req, 1'b1);
			cpu_u.io_write(clr_ports[i], 8'(i));
			wait_n(4);
			check({edge_req, mreq}, 2'b00);
		end
		edge_pin = 1'b0;
		$display("test edge latch done");

		init_ctl(8'h20, 8'h00);
		for (i = 0; i < 8; i++) begin
			reqs = (8'h01 << i) | 8'h80;
			wait_n(3);
			cpu_u.arm_core();
			cpu_u.serve(target, ans);
			check({ans, target}, {1'b1, 10'h000, 8'h20 | 8'(i), 2'b00});
		end
		init_ctl(8'h20, 8'h08);
		reqs = 8'h08;
		wait_n(3);
		cas_low = 1'b0;
		cpu_u.arm_core();
		cpu_u.serve(target, ans);
		check({ans, cas_low, cas_seen, cas_oe_n}, {1'b0, 1'b1, 3'h3, 1'b1});
		$display("test master vector done");

		slave_mode = 1'b1;
		init_ctl(8'h40, 8'h05);
		reqs = 8'h04;
		cas_in = 3'h5;
		wait_n(3);
		cas_low = 1'b0;
		cpu_u.arm_core();
		cpu_u.serve(target, ans);
		check({ans, cas_low, target}, {2'b10, 20'h0_0108});
		cas_in = 3'h3;
		wait_n(3);
		cpu_u.arm_core();
		cpu_u.serve(target, ans);
		check(ans, 1'b0);
		$display("test slave vector done");

		slave_mode = 1'b0;
		init_ctl(8'h20, 8'h00);
		reqs = 8'h01;
		cpu_u.io_write(16'h00c9, 8'h04);
		nmi_pin = 1'b0;
		wait_n(3);
		cpu_u.arm_core();
		nmi_pin = 1'b1;
		wait_n(4);
		check(nmi, 1'b1);
		cpu_u.serve(target, ans);
		check({ans, target}, {1'b1, 20'h0_0008});
		cpu_u.serve(target, ans);
		check(ans, 1'b0);
		cpu_u.arm_core();
		cpu_u.serve(target, ans);
		check({ans, target}, {1'b1, 20'h0_0080});
		cpu_u.io_write(16'h00df, 8'h00);
		check(nmi, 1'b0);
		$display("test processor service done");

		cpu_u.io_write(16'h00d7, 8'h7f);
		edge_pin = 1'b1;
		wait_n(4);
		edge_pin = 1'b0;
		rst = 1'b1;
		wait_n(2);
		rst = 1'b0;
		check_reset();
		$display("test second reset done");
		stop_test();
	end
endmodule

`default_nettype wire
